// ===== ckg_regs.svh
`ifndef CKG_REGS_SVH
`define CKG_REGS_SVH
// key storage widths
`define CKG_AES_KEY_W        256
`define CKG_HMAC_KEY_W       512
`define CKG_KEY_WORD_W       32
`define CKG_AES_WORDS        8
`define CKG_HMAC_WORDS       16
`define CKG_WORD_IDX_W       4
// number of known-answer checks in the power-up sequence
`define CKG_NUM_CHECKS       10
`define CKG_CHECK_IDX_W      4
// xts data unit limit: two to the twentieth blocks
`define CKG_XTS_MAX_BLOCKS   21'h100000
`define CKG_XTS_CNT_W        21
// fifo channels
`define CKG_NUM_CHAN         4
`define CKG_CHAN_W           2
`endif

// ===== ckg_pkg.sv
package ckg_pkg;
  typedef enum logic [1:0] {
    CKG_ST_IDLE  = 2'b00,
    CKG_ST_TEST  = 2'b01,
    CKG_ST_READY = 2'b10,
    CKG_ST_ERROR = 2'b11
  } ckg_state_t;
  // known-answer check order
  typedef enum logic [3:0] {
    CKG_KC_CCM_ENC  = 4'h0,
    CKG_KC_CCM_DEC  = 4'h1,
    CKG_KC_ECB_ENC  = 4'h2,
    CKG_KC_ECB_DEC  = 4'h3,
    CKG_KC_HMAC_S1  = 4'h4,
    CKG_KC_HMAC_S256 = 4'h5,
    CKG_KC_HMAC_S384 = 4'h6,
    CKG_KC_HMAC_S512 = 4'h7,
    CKG_KC_CMAC_GEN = 4'h8,
    CKG_KC_CMAC_VER = 4'h9
  } ckg_check_t;
endpackage : ckg_pkg

// ===== ckg_key_guard.sv
`timescale 1ns/1ps
`include "ckg_regs.svh"

// Overview of operation
// - writes to an unassigned fifo channel are dropped, channel untouched.
// - key registers are write-only; reads of them return all zeros.
// - every reset clears the aes and hmac keys to zero.
// - self-tests run automatically after reset; data paths gated until finished.
// - run ccm, ecb, cmac checks with 256-bit keys and four hmac checks.
// - a failed check enters error state and sets the failure flag.
// - in error state all data in/out and crypto operations are blocked.
// - error state ignores everything but reset; reset restarts the sequence.
// - no service after reset until all self-tests have passed.
// - no error path ever puts key bits on a readable output.
// - xts requires distinct keys and at most two to the twentieth blocks.
module ckg_key_guard
  import ckg_pkg::*;
(
  input  wire logic                          sys_clk,
  input  wire logic                          resetn,
  // key register write port, word addressed
  input  wire logic                          aes_key_we,
  input  wire logic                          aes_key_sel,
  input  wire logic [`CKG_WORD_IDX_W-1:0]    key_word_idx,
  input  wire logic [`CKG_KEY_WORD_W-1:0]    key_wdata,
  input  wire logic                          hmac_key_we,
  // key register read port
  input  wire logic                          key_re,
  output logic      [`CKG_KEY_WORD_W-1:0]    key_rdata,
  // fifo write channels
  input  wire logic [`CKG_CHAN_W-1:0]        active_chan,
  input  wire logic                          fifo_we,
  input  wire logic [`CKG_CHAN_W-1:0]        fifo_chan,
  input  wire logic [`CKG_KEY_WORD_W-1:0]    fifo_wdata,
  output logic      [`CKG_NUM_CHAN-1:0]      fifo_push,
  output logic      [`CKG_KEY_WORD_W-1:0]    fifo_push_data,
  // crypto operation request
  input  wire logic                          op_req,
  input  wire logic                          op_xts,
  input  wire logic [`CKG_XTS_CNT_W-1:0]     op_blocks,
  output logic                               op_grant,
  output logic                               op_reject,
  // data output gate from the engine
  input  wire logic                          eng_out_valid,
  input  wire logic [`CKG_KEY_WORD_W-1:0]    eng_out_data,
  output logic                               data_out_valid,
  output logic      [`CKG_KEY_WORD_W-1:0]    data_out_data,
  // known-answer check handshake with the engine
  output logic                               check_start,
  output logic      [`CKG_CHECK_IDX_W-1:0]   check_id,
  input  wire logic                          check_done,
  input  wire logic                          check_pass,
  // status
  output logic                               service_ready,
  output logic                               selftest_busy,
  output logic                               selftest_fail_flag
);

  // sequencer state and the index of the check in flight
  ckg_state_t                          state_reg;
  ckg_state_t                          state_next;
  logic [`CKG_CHECK_IDX_W-1:0]         idx_reg;
  logic [`CKG_CHECK_IDX_W-1:0]         idx_next;
  // key banks live in flip-flops; nothing below routes them to an output
  logic [`CKG_KEY_WORD_W-1:0]          aes_a_reg [`CKG_AES_WORDS];
  logic [`CKG_KEY_WORD_W-1:0]          aes_b_reg [`CKG_AES_WORDS];
  logic [`CKG_KEY_WORD_W-1:0]          hmac_reg  [`CKG_HMAC_WORDS];
  logic [`CKG_AES_WORDS-1:0]           word_same;

  // key writes only accepted while in service
  // this also keeps host key traffic away from the power-up checks
  function automatic logic key_wr_ok(input logic we, input ckg_state_t st);
    key_wr_ok = we && (st == CKG_ST_READY);
  endfunction : key_wr_ok

  wire ready_w     = (state_reg == CKG_ST_READY);
  wire last_check  = (idx_reg == 4'(`CKG_NUM_CHECKS - 1));
  wire aes_a_wr    = key_wr_ok(aes_key_we, state_reg) && !aes_key_sel;
  wire aes_b_wr    = key_wr_ok(aes_key_we, state_reg) && aes_key_sel;
  wire hmac_wr     = key_wr_ok(hmac_key_we, state_reg);
  // two zeroed banks compare equal, so xts stays refused until the banks differ in at least one word
  // distinct xts keys
  wire keys_equal  = &word_same;
  // the limit itself is still a legal length
  // xts length limit
  wire xts_too_big = (op_blocks > `CKG_XTS_MAX_BLOCKS);
  wire op_bad      = op_xts && (keys_equal || xts_too_big);
  wire fifo_ok     = fifo_we && ready_w && (fifo_chan == active_chan);

  // one decode feeds grant and reject, so the two can never both rise
  // operation permission
  wire op_ok       = ready_w && !op_bad;
  wire out_open    = eng_out_valid && ready_w;

  // next values of the check handshake and status registers
  wire start_next  = (state_next == CKG_ST_TEST) &&
                     ((state_reg == CKG_ST_IDLE) || check_done);
  wire busy_next   = (state_next == CKG_ST_TEST) || (state_next == CKG_ST_IDLE);
  wire ready_next  = (state_next == CKG_ST_READY);
  wire error_next  = (state_next == CKG_ST_ERROR);

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    case (state_reg)
      CKG_ST_IDLE: begin
        state_next = CKG_ST_TEST;
        idx_next   = '0;
      end
      // one check answered at a time; back-to-back answers are fine
      // walk every check
      CKG_ST_TEST: begin
        if (check_done) begin
          if (!check_pass) begin
            state_next = CKG_ST_ERROR;
          end else if (last_check) begin
            state_next = CKG_ST_READY;
          end else begin
            idx_next = idx_reg + 4'h1;
          end
        end
      end
      // ready and error are terminal; only the asynchronous reset leaves them
      CKG_ST_READY: state_next = CKG_ST_READY;
      CKG_ST_ERROR: state_next = CKG_ST_ERROR;
      default:      state_next = CKG_ST_ERROR;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= CKG_ST_IDLE;
      idx_reg   <= '0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
    end
  end

  // per-word key storage; one loop covers all three banks
  genvar gi;
  generate
    for (gi = 0; gi < `CKG_HMAC_WORDS; gi++) begin : g_key
      wire hit = (key_word_idx == 4'(gi));
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          hmac_reg[gi] <= '0;
        end else if (hmac_wr && hit) begin
          hmac_reg[gi] <= key_wdata;
        end
      end
      // words 8 to 15 exist only in the hmac bank; aes writes there fall away
      if (gi < `CKG_AES_WORDS) begin : g_aes
        always_ff @(posedge sys_clk or negedge resetn) begin
          if (!resetn) begin
            aes_a_reg[gi] <= '0;
            aes_b_reg[gi] <= '0;
          end else begin
            if (aes_a_wr && hit) aes_a_reg[gi] <= key_wdata;
            if (aes_b_wr && hit) aes_b_reg[gi] <= key_wdata;
          end
        end
        assign word_same[gi] = (aes_a_reg[gi] == aes_b_reg[gi]);
      end
    end
  endgenerate

  // outputs: gated by state, keys never routed to any read path
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // everything quiet: no service, no failure, no check running
      key_rdata          <= '0;
      fifo_push          <= '0;
      fifo_push_data     <= '0;
      op_grant           <= 1'b0;
      op_reject          <= 1'b0;
      data_out_valid     <= 1'b0;
      data_out_data      <= '0;
      check_start        <= 1'b0;
      check_id           <= '0;
      service_ready      <= 1'b0;
      selftest_busy      <= 1'b0;
      selftest_fail_flag <= 1'b0;
    end else begin
      key_rdata          <= '0;
      fifo_push          <= fifo_ok ? `CKG_NUM_CHAN'(1) << fifo_chan : '0;
      fifo_push_data     <= fifo_ok ? fifo_wdata : '0;
      op_grant           <= op_req && op_ok;
      op_reject          <= op_req && !op_ok;
      // gate data output
      // data is zeroed with the valid, so nothing stale leaks out
      data_out_valid     <= out_open;
      data_out_data      <= out_open ? eng_out_data : '0;
      // a check starts on entry to the sequence and after each passing answer but the last
      check_start        <= start_next;
      check_id           <= idx_next;
      // status follows the next state so it moves in step with the sequencer
      service_ready      <= ready_next;
      selftest_busy      <= busy_next;
      selftest_fail_flag <= selftest_fail_flag || error_next;
    end
  end

  // the read strobe is taken but steers nothing: a key read only ever sees zero
  wire unused_re = key_re;

endmodule : ckg_key_guard

// ===== ckg_key_guard_assertions.sv
`timescale 1ns/1ps
module ckg_guard_checker
  import ckg_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [31:0] key_rdata,
  input wire logic [1:0]  active_chan,
  input wire logic        fifo_we,
  input wire logic [1:0]  fifo_chan,
  input wire logic [3:0]  fifo_push,
  input wire logic        op_req,
  input wire logic        op_grant,
  input wire logic        data_out_valid,
  input wire logic        check_done,
  input wire logic        check_pass,
  input wire logic        service_ready,
  input wire logic        selftest_fail_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  key_zero_a: assert property (key_rdata == 32'h0) else $error("key read not zero");
  chan_block_a: assert property (fifo_we && fifo_chan != active_chan |=>
    fifo_push == 4'h0) else $error("unassigned channel pushed");
  chan_push_a: assert property (fifo_we && fifo_chan == active_chan && service_ready
    |=> fifo_push == (4'h1 << $past(fifo_chan))) else $error("assigned push wrong");
  fail_set_a: assert property (check_done && !check_pass && !service_ready
    && !selftest_fail_flag |=> selftest_fail_flag) else $error("fail flag not set");
  fail_hold_a: assert property (selftest_fail_flag |=> selftest_fail_flag
    && !service_ready) else $error("error state left");
  err_block_a: assert property (selftest_fail_flag |=> !data_out_valid
    && fifo_push == 4'h0 && !op_grant) else $error("traffic in error state");
  gate_off_a: assert property (!service_ready [*2] |-> !data_out_valid)
    else $error("output while not ready");
  op_refuse_a: assert property (op_req && !service_ready |=> !op_grant)
    else $error("grant while not ready");
  ready_rise_a: assert property ($rose(service_ready) |-> $past(check_done)
    && $past(check_pass) && !selftest_fail_flag) else $error("ready without pass");
endmodule : ckg_guard_checker

bind ckg_key_guard ckg_guard_checker u_ckg_guard_checker (.sys_clk, .resetn, .key_rdata,
  .active_chan, .fifo_we, .fifo_chan, .fifo_push, .op_req, .op_grant, .data_out_valid,
  .check_done, .check_pass, .service_ready, .selftest_fail_flag);

// ===== ckg_engine_model.sv
`timescale 1ns/1ps
module ckg_engine_model (
  input  wire logic       sys_clk,
  input  wire logic       check_start,
  input  wire logic [3:0] check_id,
  input  wire logic [3:0] fail_id,
  input  wire logic       slow,
  output logic            check_done,
  output logic            check_pass
);
  initial check_done = 1'b0;
  initial check_pass = 1'b0;
  // pass line toggles between answers so a stale value never reads as a result
  always @(posedge sys_clk) begin
    check_done <= 1'b0;
    check_pass <= ~check_pass;
    if (check_start) begin
      repeat (slow ? 3 : 0) @(posedge sys_clk);
      check_done <= 1'b1;
      check_pass <= (check_id != fail_id);
    end
  end
endmodule : ckg_engine_model

// ===== tb_ckg_key_guard.sv
`timescale 1ns/1ps
`include "ckg_regs.svh"
module tb_ckg_key_guard;
  logic sys_clk = 1'b0, resetn = 1'b0, aes_key_we = 1'b0, aes_key_sel = 1'b0;
  logic hmac_key_we = 1'b0, key_re = 1'b0, fifo_we = 1'b0, op_req = 1'b0, op_xts = 1'b0;
  logic eng_out_valid = 1'b1, slow = 1'b0;
  logic [3:0] key_word_idx = 4'h0, fail_id = 4'hF;
  logic [31:0] key_wdata = 32'h0, fifo_wdata = 32'h0, eng_out_data = 32'h5A5A0001;
  logic [1:0] active_chan = 2'h2, fifo_chan = 2'h0;
  logic [20:0] op_blocks = 21'h0;
  wire [31:0] key_rdata, fifo_push_data, data_out_data;
  wire [3:0] fifo_push, check_id;
  wire op_grant, op_reject, data_out_valid, check_start, check_done, check_pass;
  wire service_ready, selftest_busy, selftest_fail_flag;
  int bad_count = 0, comparisons = 0;
  ckg_key_guard u_ckg_key_guard (.sys_clk, .resetn, .aes_key_we, .aes_key_sel, .key_word_idx,
    .key_wdata, .hmac_key_we, .key_re, .key_rdata, .active_chan, .fifo_we, .fifo_chan,
    .fifo_wdata, .fifo_push, .fifo_push_data, .op_req, .op_xts, .op_blocks, .op_grant,
    .op_reject, .eng_out_valid, .eng_out_data, .data_out_valid, .data_out_data, .check_start,
    .check_id, .check_done, .check_pass, .service_ready, .selftest_busy, .selftest_fail_flag);
  ckg_engine_model u_ckg_engine_model (.sys_clk, .check_start, .check_id, .fail_id, .slow,
    .check_done, .check_pass);
  always #2 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // reset, then follow the self-test sequence to ready or error
  task automatic boot(input logic [3:0] fid, input logic sl, input logic ok);
    int n;
    logic [3:0] id;
    n = 0;
    id = 4'h0;
    @(posedge sys_clk);
    resetn <= 1'b0;
    fail_id <= fid;
    slow <= sl;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    while (service_ready !== 1'b1 && selftest_fail_flag !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      #1 n++;
      if (check_start === 1'b1) begin
        check(check_id, id);
        id++;
      end
      if (service_ready !== 1'b1) begin
        check(data_out_valid, 1'b0);
        if (selftest_fail_flag !== 1'b1) check(selftest_busy, 1'b1);
      end
    end
    if (n >= 200) begin
      bad_count++;
      close_out();
    end else begin
      check(selftest_fail_flag, !ok);
      check(service_ready, ok);
      check(selftest_busy, 1'b0);
      check(id, ok ? 4'hA : fid + 4'h1);
    end
  endtask : boot
  task automatic op(input logic x, input logic [20:0] blk, input logic g);
    @(posedge sys_clk);
    op_req <= 1'b1;
    op_xts <= x;
    op_blocks <= blk;
    @(posedge sys_clk);
    op_req <= 1'b0;
    #1 check({op_grant, op_reject}, {g, !g});
  endtask : op
  task automatic fifo(input logic [1:0] ch, input logic on);
    @(posedge sys_clk);
    fifo_we <= 1'b1;
    fifo_chan <= ch;
    fifo_wdata <= 32'hC0DE0000 + ch;
    @(posedge sys_clk);
    fifo_we <= 1'b0;
    #1 check(fifo_push, on && ch == active_chan ? 4'h1 << ch : 4'h0);
    check(fifo_push_data, on && ch == active_chan ? 32'hC0DE0000 + ch : 32'h0);
  endtask : fifo
  task automatic wr_key(input logic hm, input logic sel, input logic [3:0] i);
    @(posedge sys_clk);
    aes_key_we <= !hm;
    hmac_key_we <= hm;
    aes_key_sel <= sel;
    key_word_idx <= i;
    key_wdata <= {28'hA11CE00, sel, i[2:0]};
    key_re <= 1'b1;
    @(posedge sys_clk);
    aes_key_we <= 1'b0;
    hmac_key_we <= 1'b0;
    #1 check(key_rdata, 32'h0);
  endtask : wr_key
  task automatic t_fail;
    boot(4'h0, 1'b0, 1'b0);
    op(1'b0, 21'h1, 1'b0);
    fifo(2'h2, 1'b0);
    boot(4'h9, 1'b1, 1'b0);
  endtask : t_fail
  task automatic t_service;
    boot(4'hF, 1'b1, 1'b1);
    @(posedge sys_clk);
    #1 check(data_out_data, eng_out_data);
    check(data_out_valid, 1'b1);
    @(posedge sys_clk);
    eng_out_valid <= 1'b0;
    @(posedge sys_clk);
    eng_out_valid <= 1'b1;
    #1 check(data_out_valid, 1'b0);
    check(data_out_data, 32'h0);
    for (int c = 0; c < 4; c++) fifo(c[1:0], 1'b1);
    op(1'b1, 21'h1, 1'b0);
    for (int w = 0; w < 16; w++) wr_key(1'b1, 1'b0, w[3:0]);
    for (int w = 0; w < 16; w++) wr_key(1'b0, w[3], {1'b0, w[2:0]});
    op(1'b1, `CKG_XTS_MAX_BLOCKS, 1'b1);
    op(1'b1, `CKG_XTS_MAX_BLOCKS + 21'h1, 1'b0);
    op(1'b0, 21'h1, 1'b1);
  endtask : t_service
  task automatic t_zero;
    boot(4'hF, 1'b0, 1'b1);
    op(1'b1, 21'h1, 1'b0);
    @(posedge sys_clk);
    active_chan <= 2'h1;
    fifo(2'h1, 1'b1);
    fifo(2'h2, 1'b1);
  endtask : t_zero
  initial begin
    t_fail();
    t_service();
    t_zero();
    close_out();
  end
endmodule : tb_ckg_key_guard
